//--- common/dpl_pkg.sv
// Purpose: shared constants and carrier types for the dual-phase resonant control scheduler
// Assumes: 10 MHz system clock, synchronous active-high reset
// Notes:   currents in 0.1 A units, voltages in 0.1 V units, frequencies in kHz
package dpl_pkg;

    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned TICK_HZ        = 50_000;
    localparam int unsigned TICK_CYC       = CLK_HZ / TICK_HZ;
    localparam int unsigned FINE_STEP_PS   = 150;
    localparam int unsigned CLK_PERIOD_PS  = 1_000_000_000 / (CLK_HZ / 1000);
    localparam int unsigned FINE_PER_CYC   = CLK_PERIOD_PS / FINE_STEP_PS;
    localparam logic [15:0] BAL_DIFF_MAX   = 16'h0032;
    localparam logic [15:0] FREQ_MIN       = 16'h0032;
    localparam logic [15:0] FREQ_MAX       = 16'h01f4;
    localparam logic [15:0] FREQ_RST       = 16'h01f4;
    localparam logic [15:0] FREQ_TRIM      = 16'h0002;
    localparam logic [15:0] VT_RAMP_STEP   = 16'h0001;
    localparam logic [15:0] TRACK_BIG_ERR  = 16'h0020;
    localparam logic [15:0] KP             = 16'h0004;
    localparam logic [15:0] KI             = 16'h0001;
    localparam logic [7:0]  DEAD_RST       = 8'h10;
    localparam logic [15:0] LOAD_JUMP      = 16'h0064;

    typedef struct packed {
        logic [15:0] v_out;
        logic [15:0] i_ph1;
        logic [15:0] i_ph2;
    } dpl_sense_s;

    typedef struct packed {
        logic        cur_limit;
        logic        cap_mode;
        logic        burst_off;
    } dpl_event_s;

    typedef struct packed {
        logic [15:0] shed_on;
        logic [15:0] shed_off;
        logic [15:0] step_on;
    } dpl_thr_s;

    typedef enum logic [3:0] {
        TS_IDLE  = 4'b0000,
        TS_LIMIT = 4'b0001,
        TS_CAP   = 4'b0010,
        TS_BURST = 4'b0011,
        TS_PI    = 4'b0100,
        TS_START = 4'b0101,
        TS_SHED  = 4'b0110,
        TS_SR    = 4'b0111,
        TS_DEAD  = 4'b1000,
        TS_CONV  = 4'b1001
    } dpl_task_e;

endpackage

//--- verilog/dpl_pwm_phase.sv
// Purpose: one half-bridge drive with dead time rounded up to whole clocks and conversion trigger
// Assumes: half period given in clock cycles, dead time in fine steps
// Notes:   new period and dead time load only at period start
module dpl_pwm_phase
    import dpl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        en,
    input  wire logic [15:0] half_cyc,
    input  wire logic [7:0]  dead_fine,
    output logic             hs,
    output logic             ls,
    output logic             conv_req
);
    import dpl_pkg::*;

    logic [15:0] cnt_r, cnt_nxt, half_r, half_nxt;
    logic [7:0]  dead_r, dead_nxt;
    logic        lvl_r, lvl_nxt, hs_r, hs_nxt, ls_r, ls_nxt, req_r, req_nxt;
    logic [15:0] dead_cyc;

    // dead time rounded up to whole clocks; residue placement is left to the pad cell
    assign dead_cyc = 16'((32'(dead_r) + FINE_PER_CYC - 1) / FINE_PER_CYC);

    always_comb begin
        cnt_nxt  = cnt_r + 16'h0001;
        half_nxt = half_r;
        dead_nxt = dead_r;
        lvl_nxt  = lvl_r;
        req_nxt  = 1'b0;
        if (!en) begin
            cnt_nxt = 16'h0000;
            lvl_nxt = 1'b0;
        end else if (cnt_r + 16'h0001 >= half_r) begin
            cnt_nxt = 16'h0000;
            lvl_nxt = !lvl_r;
            req_nxt = 1'b1;
            if (lvl_r) begin
                // shadow load at period boundary avoids unsafe partial edges
                half_nxt = (half_cyc == 16'h0000) ? 16'h0001 : half_cyc;
                dead_nxt = dead_fine;
            end
        end
        hs_nxt = en && lvl_nxt && (cnt_nxt >= dead_cyc);
        ls_nxt = en && !lvl_nxt && (cnt_nxt >= dead_cyc);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r  <= 16'h0000;
            half_r <= 16'h0001;
            dead_r <= DEAD_RST;
            lvl_r  <= 1'b0;
            hs_r   <= 1'b0;
            ls_r   <= 1'b0;
            req_r  <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            half_r <= half_nxt;
            dead_r <= dead_nxt;
            lvl_r  <= lvl_nxt;
            hs_r   <= hs_nxt;
            ls_r   <= ls_nxt;
            req_r  <= req_nxt;
        end
    end

    assign hs       = hs_r;
    assign ls       = ls_r;
    assign conv_req = req_r;

    no_overlap_a: assert property (@(posedge clk) disable iff (rst)
        !(hs && ls)) else $error("both switches on");
    toggle_req_a: assert property (@(posedge clk) disable iff (rst)
        (en && $past(en) && lvl_r != $past(lvl_r)) |-> conv_req)
        else $error("edge without conversion request");
endmodule

//--- verilog/dpl_ctrl_top.sv
// Purpose: control tick scheduler, PI regulator, current balancer and phase shedding
// Assumes: sensed values arrive already converted and stable between ticks
// Notes:   background tracking only runs while the tick sequence is idle
module dpl_ctrl_top
    import dpl_pkg::*;
(
    input  wire logic           CLK,
    input  wire logic           SYS_RST,
    input  wire dpl_pkg::dpl_sense_s SENSE,
    input  wire dpl_pkg::dpl_event_s EVENTS,
    input  wire dpl_pkg::dpl_thr_s   THR_LOW_V,
    input  wire dpl_pkg::dpl_thr_s   THR_HIGH_V,
    input  wire logic [15:0]    VT_SETTING,
    input  wire logic [15:0]    VT_HI_LEVEL,
    input  wire logic           RUN_EN,
    input  wire logic [7:0]     DEAD_FINE,
    output logic                PH1_HS,
    output logic                PH1_LS,
    output logic                PH2_HS,
    output logic                PH2_LS,
    output logic                RES_CONV_REQ,
    output logic                BG_CONV_REQ,
    output logic                SR_EN,
    output logic                PH2_ACTIVE,
    output logic                TICK_BUSY,
    output logic [15:0]         FREQ1,
    output logic [15:0]         FREQ2
);
    import dpl_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] clampf(input logic signed [17:0] v);
        if (v < $signed({2'b00, FREQ_MIN}))      clampf = FREQ_MIN;
        else if (v > $signed({2'b00, FREQ_MAX})) clampf = FREQ_MAX;
        else                                     clampf = v[15:0];
    endfunction

    function automatic logic [15:0] half_of(input logic [15:0] khz);
        half_of = 16'((CLK_HZ / 2000) / ((khz == 16'h0000) ? 32'd1 : 32'(khz)));
    endfunction

    // ----------------------------------------
    // tick timer and task sequencer
    // ----------------------------------------
    logic [15:0] tcnt_r, tcnt_nxt;
    logic        tick;
    dpl_task_e   task_r, task_nxt;

    always_comb begin
        tick     = (tcnt_r == 16'(TICK_CYC - 1));
        tcnt_nxt = tick ? 16'h0000 : tcnt_r + 16'h0001;
        task_nxt = task_r;
        case (task_r)
            TS_IDLE:  task_nxt = tick ? TS_LIMIT : TS_IDLE;
            TS_LIMIT: task_nxt = TS_CAP;
            TS_CAP:   task_nxt = TS_BURST;
            TS_BURST: task_nxt = TS_PI;
            TS_PI:    task_nxt = TS_START;
            TS_START: task_nxt = TS_SHED;
            TS_SHED:  task_nxt = TS_SR;
            TS_SR:    task_nxt = TS_DEAD;
            TS_DEAD:  task_nxt = TS_CONV;
            TS_CONV:  task_nxt = TS_IDLE;
            default:  task_nxt = TS_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tcnt_r <= 16'h0000;
            task_r <= TS_IDLE;
        end else begin
            tcnt_r <= tcnt_nxt;
            task_r <= task_nxt;
        end
    end

    // ----------------------------------------
    // control state
    // ----------------------------------------
    logic [15:0] vt_r, vt_nxt, f_pi_r, f_pi_nxt, bal_r, bal_nxt, f1_r, f1_nxt, f2_r, f2_nxt;
    logic [15:0] itot_prev_r, itot_prev_nxt;
    logic signed [23:0] integ_r, integ_nxt;
    logic        lim_r, lim_nxt, cap_r, cap_nxt, burst_r, burst_nxt;
    logic        ph1_r, ph1_nxt, ph2_r, ph2_nxt, sr_r, sr_nxt, bg_r, bg_nxt;
    logic        jump_r, jump_nxt;
    logic [7:0]  dead_r, dead_nxt;
    logic [15:0] itot, err_abs, step, idiff;
    logic signed [17:0] err, pi_sum;
    dpl_thr_s    thr;
    logic        bg_ok;

    always_comb begin
        itot    = SENSE.i_ph1 + SENSE.i_ph2;
        thr     = (vt_r >= VT_HI_LEVEL) ? THR_HIGH_V : THR_LOW_V;
        err     = $signed({2'b00, vt_r}) - $signed({2'b00, SENSE.v_out});
        pi_sum  = 18'sd0;
        err_abs = (f_pi_r > bal_r) ? f_pi_r - bal_r : bal_r - f_pi_r;
        // faster steps while far away or with one phase carrying all the load
        step    = (err_abs > TRACK_BIG_ERR) ? (ph2_r ? 16'h0004 : 16'h0008)
                                            : (ph2_r ? 16'h0001 : 16'h0002);
        idiff   = (SENSE.i_ph1 > SENSE.i_ph2) ? SENSE.i_ph1 - SENSE.i_ph2
                                              : SENSE.i_ph2 - SENSE.i_ph1;
        bg_ok   = (task_r == TS_IDLE) && !tick;
        vt_nxt  = vt_r;   f_pi_nxt = f_pi_r; bal_nxt = bal_r;
        f1_nxt  = f1_r;   f2_nxt   = f2_r;   integ_nxt = integ_r;
        lim_nxt = lim_r;  cap_nxt  = cap_r;  burst_nxt = burst_r;
        ph1_nxt = ph1_r;  ph2_nxt  = ph2_r;  sr_nxt  = sr_r;
        bg_nxt  = 1'b0;   dead_nxt = dead_r; jump_nxt = jump_r;
        itot_prev_nxt = itot_prev_r;
        case (task_r)
            TS_LIMIT: lim_nxt = EVENTS.cur_limit;
            TS_CAP:   cap_nxt = EVENTS.cap_mode;
            TS_BURST: begin
                burst_nxt = EVENTS.burst_off;
                ph1_nxt   = RUN_EN && !EVENTS.burst_off && !cap_r;
            end
            TS_PI: begin
                // higher frequency lowers gain, so positive error lowers frequency
                integ_nxt = integ_r + 24'(err * $signed({2'b00, KI}));
                pi_sum    = 18'(integ_r >>> 4) + 18'(err * $signed({2'b00, KP}));
                f_pi_nxt  = clampf($signed({2'b00, FREQ_RST}) - pi_sum);
            end
            TS_START: begin
                if (!ph1_r) vt_nxt = 16'h0000;
                else if (vt_r + VT_RAMP_STEP < VT_SETTING) vt_nxt = vt_r + VT_RAMP_STEP;
                else vt_nxt = VT_SETTING;
            end
            TS_SHED: begin
                jump_nxt = (itot > itot_prev_r + LOAD_JUMP);
                itot_prev_nxt = itot;
                if (!ph1_r) ph2_nxt = 1'b0;
                else if (itot >= thr.step_on && jump_nxt) ph2_nxt = 1'b1;
                else if (!ph2_r && itot > thr.shed_on) ph2_nxt = 1'b1;
                else if (ph2_r && itot < thr.shed_off) ph2_nxt = 1'b0;
                if (lim_r || cap_r || jump_nxt || (itot_prev_r > itot + LOAD_JUMP))
                    bal_nxt = f_pi_r;
            end
            TS_SR:    sr_nxt   = ph1_r && (vt_r == VT_SETTING);
            TS_DEAD: begin
                dead_nxt = DEAD_FINE;
                f1_nxt   = bal_r;
                f2_nxt   = bal_r;
                if (ph2_r && idiff > BAL_DIFF_MAX) begin
                    // the heavier phase moves up in frequency to shed current
                    if (SENSE.i_ph1 > SENSE.i_ph2) f1_nxt = clampf(18'(bal_r + FREQ_TRIM));
                    else                           f2_nxt = clampf(18'(bal_r + FREQ_TRIM));
                end
            end
            TS_CONV:  bg_nxt = 1'b1;
            default: begin
                if (bg_ok && bal_r != f_pi_r) begin
                    if (err_abs <= step) bal_nxt = f_pi_r;
                    else if (f_pi_r > bal_r) bal_nxt = bal_r + step;
                    else bal_nxt = bal_r - step;
                end
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            vt_r <= 16'h0000;  f_pi_r <= FREQ_RST; bal_r <= FREQ_RST;
            f1_r <= FREQ_RST;  f2_r <= FREQ_RST;   integ_r <= 24'sd0;
            lim_r <= 1'b0;     cap_r <= 1'b0;      burst_r <= 1'b0;
            ph1_r <= 1'b0;     ph2_r <= 1'b0;      sr_r <= 1'b0;
            bg_r <= 1'b0;      dead_r <= DEAD_RST; jump_r <= 1'b0;
            itot_prev_r <= 16'h0000;
        end else begin
            vt_r <= vt_nxt;    f_pi_r <= f_pi_nxt; bal_r <= bal_nxt;
            f1_r <= f1_nxt;    f2_r <= f2_nxt;     integ_r <= integ_nxt;
            lim_r <= lim_nxt;  cap_r <= cap_nxt;   burst_r <= burst_nxt;
            ph1_r <= ph1_nxt;  ph2_r <= ph2_nxt;   sr_r <= sr_nxt;
            bg_r <= bg_nxt;    dead_r <= dead_nxt; jump_r <= jump_nxt;
            itot_prev_r <= itot_prev_nxt;
        end
    end

    // ----------------------------------------
    // phase drives
    // ----------------------------------------
    logic req1, req2;

    dpl_pwm_phase u_ph1 (
        .clk       (CLK),
        .rst       (SYS_RST),
        .en        (ph1_r),
        .half_cyc  (half_of(f1_r)),
        .dead_fine (dead_r),
        .hs        (PH1_HS),
        .ls        (PH1_LS),
        .conv_req  (req1)
    );

    dpl_pwm_phase u_ph2 (
        .clk       (CLK),
        .rst       (SYS_RST),
        .en        (ph2_r && ph1_r),
        .half_cyc  (half_of(f2_r)),
        .dead_fine (dead_r),
        .hs        (PH2_HS),
        .ls        (PH2_LS),
        .conv_req  (req2)
    );

    assign RES_CONV_REQ = req1 || req2;
    // queued resonant requests win over the background scan
    assign BG_CONV_REQ  = bg_r && !(req1 || req2);
    assign SR_EN        = sr_r;
    assign PH2_ACTIVE   = ph2_r;
    assign TICK_BUSY    = (task_r != TS_IDLE);
    assign FREQ1        = f1_r;
    assign FREQ2        = f2_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence tick_run_s;
        (task_r == TS_LIMIT) ##4 (task_r == TS_START) ##4 (task_r == TS_CONV);
    endsequence

    tick_start_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        tick |=> (task_r == TS_LIMIT)) else $error("tick did not start sequence");
    tick_order_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (task_r == TS_IDLE && tick) |=> tick_run_s) else $error("task order broken");
    bg_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (task_r != TS_IDLE && task_r != TS_SHED) |=> $stable(bal_r))
        else $error("balancer moved during tick");
    ph2_dep_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !ph1_r |-> ##[1:3] (!PH2_HS && !PH2_LS)) else $error("phase two without one");
    shed_hyst_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (task_r == TS_SHED && ph1_r && ph2_r && itot >= thr.shed_off) |=> ph2_r)
        else $error("phase two dropped above low threshold");
    fast_fix_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (task_r == TS_SHED && lim_r) |=> (bal_r == $past(f_pi_r)))
        else $error("limit event not applied");
    bg_conv_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (task_r == TS_CONV && !tick) |=> ##[0:1] (bg_r)) else $error("no background conversion");
    vt_bound_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (task_r == TS_START && ph1_r) |=> (vt_r <= VT_SETTING || vt_r == $past(vt_r) + 16'h0001))
        else $error("target overshoot");
endmodule

//--- verification/dpl_stage_model.sv
// Purpose: behavioural power stage behind the gate drives, reporting sensed values
// Assumes: load current, current skew and output voltage are set by the bench
// Notes:   a leg counts as conducting for 255 cycles after its last high-side rise
module dpl_stage_model
    import dpl_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           ph1_hs,
    input  wire logic           ph1_ls,
    input  wire logic           ph2_hs,
    input  wire logic           ph2_ls,
    input  wire logic [15:0]    load_i,
    input  wire logic [15:0]    skew,
    input  wire logic [15:0]    v_meas,
    output dpl_pkg::dpl_sense_s sense,
    output logic                overlap
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] act1_r;
    logic [7:0] act2_r;
    logic       hs1_r;
    logic       hs2_r;

    // ------------------------------------------------------------
    // conduction tracking
    // ------------------------------------------------------------
    // the hold time bridges the slowest switching period, 200 cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            act1_r  <= 8'h00;
            act2_r  <= 8'h00;
            overlap <= 1'b0;
        end else begin
            act1_r <= (ph1_hs && !hs1_r) ? 8'hff : act1_r - {7'h00, act1_r != 8'h00};
            act2_r <= (ph2_hs && !hs2_r) ? 8'hff : act2_r - {7'h00, act2_r != 8'h00};
            if ((ph1_hs && ph1_ls) || (ph2_hs && ph2_ls)) begin
                overlap <= 1'b1;
            end
        end
        hs1_r <= ph1_hs;
        hs2_r <= ph2_hs;
    end

    // ------------------------------------------------------------
    // sensed values
    // ------------------------------------------------------------
    // a leg that is not switching delivers nothing, like the real stage
    always_comb begin
        sense.v_out = v_meas;
        sense.i_ph1 = 16'h0000;
        sense.i_ph2 = 16'h0000;
        if (act1_r != 8'h00 && act2_r != 8'h00) begin
            sense.i_ph1 = (load_i >> 1) + skew;
            sense.i_ph2 = (load_i >> 1) - skew;
        end else if (act1_r != 8'h00) begin
            sense.i_ph1 = load_i;
        end else if (act2_r != 8'h00) begin
            sense.i_ph2 = load_i;
        end
    end
endmodule

//--- verification/dual_phase_llc_control_scheduler_test.sv
// Purpose: self-checking bench for tick scheduling, drive waveform, balance and shedding
// Assumes: 10 MHz clock, inputs change 10 ns after each rising edge
// Notes:   each row waits 15 ticks; a 20 to 40 target step passes level 30 within 10 ticks
module dual_phase_llc_control_scheduler_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dpl_pkg::*;

    typedef struct packed {
        logic [15:0] vt;
        logic [15:0] load;
        logic        run;
        logic        ph2;
    } dpl_row_s;

    localparam int ROWS = 13;
    // targets 20 and 40 sit either side of the high-threshold level 30
    dpl_row_s   rows [ROWS] = '{
        '{16'h0014, 16'h0096, 1'b1, 1'b0}, '{16'h0014, 16'h00fa, 1'b1, 1'b1},
        '{16'h0014, 16'h0096, 1'b1, 1'b1}, '{16'h0014, 16'h0032, 1'b1, 1'b0},
        '{16'h0014, 16'h0096, 1'b1, 1'b0}, '{16'h0028, 16'h0096, 1'b1, 1'b0},
        '{16'h0028, 16'h00fa, 1'b1, 1'b0}, '{16'h0028, 16'h015e, 1'b1, 1'b1},
        '{16'h0028, 16'h0078, 1'b1, 1'b0}, '{16'h0028, 16'h015e, 1'b0, 1'b0},
        '{16'h0028, 16'h015e, 1'b1, 1'b1}, '{16'h0014, 16'h0032, 1'b1, 1'b0},
        '{16'h0014, 16'h01c2, 1'b1, 1'b1}};
    dpl_thr_s   thr_lo = '{16'h00c8, 16'h0064, 16'h0190};
    dpl_thr_s   thr_hi = '{16'h012c, 16'h0096, 16'h0258};
    dpl_event_s events;
    dpl_sense_s sense;
    logic       clk, sys_rst, run_en, overlap, lo, sr_en;
    logic       ph1_hs, ph1_ls, ph2_hs, ph2_ls, res_req, bg_req, ph2_act, busy;
    logic [15:0] vt_setting, load_i, skew, freq1, freq2, f;
    int          n_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;

    dpl_ctrl_top dut (
        .CLK(clk), .SYS_RST(sys_rst), .SENSE(sense), .EVENTS(events),
        .THR_LOW_V(thr_lo), .THR_HIGH_V(thr_hi), .VT_SETTING(vt_setting),
        .VT_HI_LEVEL(16'h001e), .RUN_EN(run_en), .DEAD_FINE(8'h10),
        .PH1_HS(ph1_hs), .PH1_LS(ph1_ls), .PH2_HS(ph2_hs), .PH2_LS(ph2_ls),
        .RES_CONV_REQ(res_req), .BG_CONV_REQ(bg_req), .SR_EN(sr_en), .PH2_ACTIVE(ph2_act),
        .TICK_BUSY(busy), .FREQ1(freq1), .FREQ2(freq2));

    dpl_stage_model stage (
        .clk(clk), .rst(sys_rst), .ph1_hs(ph1_hs), .ph1_ls(ph1_ls), .ph2_hs(ph2_hs),
        .ph2_ls(ph2_ls), .load_i(load_i), .skew(skew), .v_meas(16'h0000),
        .sense(sense), .overlap(overlap));

    // ------------------------------------------------------------
    // clock, timeout and reporting
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // the whole sequence needs about 47000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        int per;
        int hs_n;
        int ls_n;
        int res_n;
        int busy_n;
        sys_rst = 1'b1;
        run_en = 1'b0;
        vt_setting = 16'h0014;
        load_i = 16'h0000;
        skew = 16'h0000;
        events = '0;
        step(6);
        check("freq1 in reset", freq1, FREQ_RST);
        check("freq2 in reset", freq2, FREQ_RST);
        check("outputs in reset", 16'({ph1_hs, ph1_ls, ph2_hs, ph2_ls, res_req, bg_req, ph2_act}), 16'h0000);
        sys_rst = 1'b0;
        per = 0;
        while (bg_req !== 1'b1 && per < 400) begin
            step(1);
            per++;
        end
        per = 0;
        busy_n = 0;
        do begin
            step(1);
            per++;
            busy_n += (busy === 1'b1);
        end while (bg_req !== 1'b1 && per < 400);
        check("tick spacing", 16'(per), 16'(TICK_CYC));
        check("tick busy span", 16'(busy_n), 16'h0009);
        step(1);
        check("background request width", 16'(bg_req), 16'h0000);
        for (int r = 0; r < ROWS; r++) begin
            vt_setting = rows[r].vt;
            load_i = rows[r].load;
            run_en = rows[r].run;
            step(15 * TICK_CYC);
            check("second phase enable", 16'(ph2_act), 16'(rows[r].ph2));
            if (!rows[r].run) begin
                check("drives while stopped", 16'({ph1_hs, ph2_hs}), 16'h0000);
                check("rectifier while stopped", 16'(sr_en), 16'h0000);
            end
        end
        events.burst_off = 1'b1;
        step(3 * TICK_CYC);
        check("burst drops second phase", 16'(ph2_act), 16'h0000);
        events.burst_off = 1'b0;
        step(15 * TICK_CYC);
        check("second phase restored", 16'(ph2_act), 16'h0001);
        skew = 16'h001e;
        step(5 * TICK_CYC);
        check("heavier phase trimmed", freq1, freq2 + FREQ_TRIM);
        skew = 16'h000a;
        step(5 * TICK_CYC);
        check("phases within band", freq1, freq2);
        skew = 16'h0000;
        load_i = 16'h0032;
        step(5 * TICK_CYC);
        per = 0;
        while (ph1_hs !== 1'b0 && per < 600) begin
            step(1);
            per++;
        end
        while (ph1_hs !== 1'b1 && per < 600) begin
            step(1);
            per++;
        end
        f = freq1;
        per = 0;
        hs_n = 0;
        ls_n = 0;
        res_n = 0;
        lo = 1'b0;
        do begin
            hs_n += (ph1_hs === 1'b1);
            ls_n += (ph1_ls === 1'b1);
            res_n += (res_req === 1'b1);
            step(1);
            per++;
            if (ph1_hs === 1'b0) lo = 1'b1;
        end while (per < 600 && !(lo && ph1_hs === 1'b1));
        check("half periods equal", 16'(hs_n), 16'(ls_n));
        check("drive period", 16'(per), 16'(2 * (5000 / int'(f))));
        check("dead gaps", 16'(per - hs_n - ls_n), 16'h0002);
        check("resonant requests", 16'(res_n), 16'h0002);
        check("no leg overlap", 16'(overlap), 16'h0000);
        check("rectifier at target", 16'(sr_en), 16'h0001);
        // limit and capacitive events together: first phase must stop, second follows
        events.cur_limit = 1'b1;
        events.cap_mode = 1'b1;
        step(3 * TICK_CYC);
        check("capacitive stop", 16'({ph1_hs, ph1_ls, ph2_act}), 16'h0000);
        events = '0;
        sys_rst = 1'b1;
        step(2);
        check("freq1 after reset", freq1, FREQ_RST);
        check("outputs after reset", 16'({ph1_hs, ph1_ls, ph2_hs, ph2_ls, ph2_act}), 16'h0000);
        sys_rst = 1'b0;
        step(2);
        check("quiet after release", 16'({ph1_hs, ph2_hs, busy, bg_req, res_req}), 16'h0000);
        test_done();
    end
endmodule
